// ---- rxcfg_receiver.sv ----
// receiver configuration registers, snapshot, guard and interference logic
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_params.svh"

// Function
// - with guard-time checking on in Type B, a too long gap between characters raises a protocol error.
// - with suppression on, an error in the first three bytes discards them and resets the receive FIFO.
// - during suppression a collision in the first bytes counts as a reception error.
// - a frame shorter than three bytes after a valid start, with suppression on, raises no receive-complete.
// - receive rate codes 2h to 7h select 26, 52, 106, 212, 424 and 847 kBd, codes 0h and 1h are reserved.
// - with the unit select low, the ignore interval is the guard count times 16 carrier periods.
// - with the unit select high, the ignore interval is the guard count times half a data bit.
// - rx_ignore is raised for the programmed 7-bit interval after transmission ends; rx_in still reaches the filter and guard check.
// - the decoder minimum threshold comes from bits 7 to 4 of the threshold register.
// - the phase detector minimum threshold comes from bits 3 to 0 of the threshold register.
// - the front-end register holds single-input, converter mode, source, reserved and collision level fields.
// - single-input select 0 means fully differential, 1 means quasi-differential input.
// - converter mode 0 means normal reception, 1 means low-power card detection.
// - source select 0h idle, 1h internal receiver, 2h Type A envelope, 3h generic coded input.
// - collision level 0h one eighth, 1h one quarter, 2h one half, 3h collision detection off.
module rxcfg_receiver
	import rxcfg_pkg::*;
#(
	parameter int          ADDR_W         = 12,
	parameter logic [11:0] EGT_MAX_CYCLES = 12'h400
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// receive path
	input  wire logic              tx_end,
	input  wire logic              type_b_mode,
	input  wire rxcfg_rx_s         rx_in,
	output rxcfg_active_s          active_cfg,
	output logic                   rx_ignore,
	output logic                   fifo_flush,
	output logic                   rx_complete,
	output logic                   protocol_error
);

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ======================================================================
	// configuration registers
	logic [7:0]    ctrl_q;
	logic [7:0]    guard_q;
	logic [7:0]    thr_q;
	logic [7:0]    fe_q;
	logic [7:0]    stat_q;
	rxcfg_active_s active_q;
	logic          in_frame_q;
	logic          type_b_q;
	logic          emd_event;

	// ======================================================================
	// write channel
	logic              aw_held_q;
	logic              w_held_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        wbyte_q;
	logic              wlane_q;
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;

	wire aw_take = s_axi_awvalid & awready_q;
	wire w_take  = s_axi_wvalid & wready_q;
	wire b_take  = bvalid_q & s_axi_bready;
	wire wr_fire = aw_held_q & w_held_q;

	wire [7:0] wr_idx   = awaddr_q[9:2];
	wire       wr_upper = (awaddr_q[ADDR_W-1:10] == '0);
	wire       wr_ctrl  = wr_upper & (wr_idx == `RXCFG_IDX_CTRL);
	wire       wr_guard = wr_upper & (wr_idx == `RXCFG_IDX_GUARD);
	wire       wr_thr   = wr_upper & (wr_idx == `RXCFG_IDX_THR);
	wire       wr_fe    = wr_upper & (wr_idx == `RXCFG_IDX_FE);
	wire       wr_stat  = wr_upper & (wr_idx == `RXCFG_IDX_STAT);
	wire       wr_hit   = wr_ctrl | wr_guard | wr_thr | wr_fe | wr_stat;
	wire       wr_en    = wr_fire & wlane_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
			awready_q <= 1'b1;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			awready_q <= aw_take ? 1'b0 : (b_take ? 1'b1 : awready_q);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			w_held_q <= 1'b0;
			wbyte_q  <= 8'h00;
			wlane_q  <= 1'b0;
			wready_q <= 1'b1;
		end else begin
			if (w_take) begin
				w_held_q <= 1'b1;
				wbyte_q  <= s_axi_wdata[7:0];
				wlane_q  <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
			wready_q <= w_take ? 1'b0 : (b_take ? 1'b1 : wready_q);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (b_take) begin
			bvalid_q <= 1'b0;
		end
	end

	// reserved and out-of-block bits are masked so they always read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q  <= `RXCFG_RST_CTRL;
			guard_q <= `RXCFG_RST_GUARD;
			thr_q   <= `RXCFG_RST_THR;
			fe_q    <= `RXCFG_RST_FE;
		end else if (wr_en) begin
			if (wr_ctrl) ctrl_q <= wbyte_q & `RXCFG_MASK_CTRL;
			if (wr_guard) guard_q <= wbyte_q;
			if (wr_thr) thr_q <= wbyte_q;
			if (wr_fe) fe_q <= wbyte_q & `RXCFG_MASK_FE;
		end
	end

	// ======================================================================
	// status: hardware set wins over a software write-one clear
	wire [7:0] stat_set = {5'h00, rx_complete, emd_event, protocol_error};
	wire [7:0] stat_clr = (wr_en & wr_stat) ? (wbyte_q & `RXCFG_STAT_W1C)
		: 8'h00;
	wire [7:0] stat_live = {3'h0, in_frame_q, rx_ignore, 3'h0};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_q <= 8'h00;
		end else begin
			stat_q <= ((stat_q & ~stat_clr) | stat_set) & `RXCFG_STAT_W1C;
		end
	end

	// ======================================================================
	// read channel
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	wire ar_take = s_axi_arvalid & arready_q;
	wire r_take  = rvalid_q & s_axi_rready;

	wire [7:0] rd_idx   = s_axi_araddr[9:2];
	wire       rd_upper = (s_axi_araddr[ADDR_W-1:10] == '0);
	wire       rd_ctrl  = rd_upper & (rd_idx == `RXCFG_IDX_CTRL);
	wire       rd_guard = rd_upper & (rd_idx == `RXCFG_IDX_GUARD);
	wire       rd_thr   = rd_upper & (rd_idx == `RXCFG_IDX_THR);
	wire       rd_fe    = rd_upper & (rd_idx == `RXCFG_IDX_FE);
	wire       rd_stat  = rd_upper & (rd_idx == `RXCFG_IDX_STAT);
	wire       rd_hit   = rd_ctrl | rd_guard | rd_thr | rd_fe | rd_stat;
	wire [7:0] rd_byte  = ({8{rd_ctrl}} & ctrl_q)
		| ({8{rd_guard}} & guard_q)
		| ({8{rd_thr}} & thr_q)
		| ({8{rd_fe}} & fe_q)
		| ({8{rd_stat}} & (stat_q | stat_live));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= {24'h00_0000, rd_byte};
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_take) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ======================================================================
	// configuration snapshot taken at start of frame
	rxcfg_active_s live_cfg;
	rxcfg_active_s cfg_now;

	assign live_cfg.single_input_select         = fe_q[7];
	assign live_cfg.converter_mode_select       = fe_q[6];
	assign live_cfg.signal_source_select        = fe_q[5:4];
	assign live_cfg.collision_threshold_level   = fe_q[1:0];
	assign live_cfg.decoder_min_threshold       = thr_q[7:4];
	assign live_cfg.phase_detector_threshold    = thr_q[3:0];
	assign live_cfg.data_bit_rate               = ctrl_q[2:0];
	assign live_cfg.disturbance_suppress_enable =
		ctrl_q[`RXCFG_CTRL_EMD_BIT];
	assign live_cfg.guard_time_check_enable     =
		ctrl_q[`RXCFG_CTRL_EGT_BIT];

	// the frame's own logic must see the new settings in its first cycle
	assign cfg_now = rx_in.sof ? live_cfg : active_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			active_q   <= '0;
			in_frame_q <= 1'b0;
			type_b_q   <= 1'b0;
		end else if (rx_in.sof) begin
			active_q   <= live_cfg;
			in_frame_q <= 1'b1;
			type_b_q   <= type_b_mode;
		end else if (rx_in.frame_end) begin
			in_frame_q <= 1'b0;
		end
	end

	assign active_cfg = active_q;

	// ======================================================================
	// extra guard time check between characters
	logic [11:0] egt_cnt_q;
	logic        seen_byte_q;
	logic        perr_q;

	wire egt_arm = in_frame_q & seen_byte_q & type_b_q
		& active_q.guard_time_check_enable;
	wire egt_hit = egt_arm & ~rx_in.byte_valid
		& (egt_cnt_q == EGT_MAX_CYCLES - 12'h001);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			egt_cnt_q   <= 12'h000;
			seen_byte_q <= 1'b0;
			perr_q      <= 1'b0;
		end else begin
			if (!in_frame_q || rx_in.byte_valid) begin
				egt_cnt_q <= 12'h000;
			end else if (egt_arm && egt_cnt_q != EGT_MAX_CYCLES) begin
				egt_cnt_q <= egt_cnt_q + 12'h001;
			end
			seen_byte_q <= rx_in.sof ? 1'b0
				: (seen_byte_q | (in_frame_q & rx_in.byte_valid));
			perr_q <= egt_hit;
		end
	end

	assign protocol_error = perr_q;

	// ======================================================================
	// guard timer and interference filter
	rxcfg_guard_timer u_guard (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.tx_end        (tx_end),
		.unit_select   (guard_q[`RXCFG_GUARD_UNIT_BIT]),
		.guard_count   (guard_q[6:0]),
		.data_bit_rate (ctrl_q[2:0]),
		.rx_ignore     (rx_ignore)
	);

	// collision level 3h switches collision detection off
	rxcfg_emd_filter u_emd (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.rx_in       (rx_in),
		.suppress    (cfg_now.disturbance_suppress_enable),
		.coll_enable (cfg_now.collision_threshold_level != 2'h3),
		.fifo_flush  (fifo_flush),
		.rx_complete (rx_complete),
		.emd_event   (emd_event)
	);

	// ======================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_cfg_snapshot: assert property (rx_in.sof |=>
		active_cfg == $past(live_cfg)) else $error("snapshot missed");
	a_cfg_hold: assert property (!rx_in.sof |=> $stable(active_cfg))
		else $error("config changed mid frame");
	a_egt_error: assert property (egt_hit |=> protocol_error
		##1 !protocol_error) else $error("guard time error wrong");
	a_egt_quiet: assert property (!active_q.guard_time_check_enable
		|=> !protocol_error) else $error("unchecked guard time error");
	a_fe_reserved: assert property (fe_q[3:2] == 2'b00)
		else $error("reserved front-end bits set");
	a_stat_sticky: assert property (protocol_error |=> stat_q[0])
		else $error("status not set");
	a_write_answer: assert property (aw_held_q && w_held_q |=> s_axi_bvalid
		&& s_axi_bresp == ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR))
		else $error("write answer wrong");
	a_read_unmapped: assert property (ar_take && !rd_hit |=>
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answer wrong");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped");

	c_write: cover property (wr_fire && wr_ctrl);
	c_read_stat: cover property (ar_take && rd_stat);
	c_frame_done: cover property (rx_in.sof ##[1:40] rx_complete);
endmodule // rxcfg_receiver
`default_nettype wire

// ---- rxcfg_params.svh ----
// offsets, field positions, reset values and timing counts of the receiver
`ifndef RXCFG_PARAMS_SVH
`define RXCFG_PARAMS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define RXCFG_IDX_CTRL   8'h35
`define RXCFG_IDX_GUARD  8'h36
`define RXCFG_IDX_THR    8'h37
`define RXCFG_IDX_FE     8'h38
`define RXCFG_IDX_STAT   8'h3F

// ==========================================================================
// field positions
`define RXCFG_CTRL_EGT_BIT  4
`define RXCFG_CTRL_EMD_BIT  3
`define RXCFG_GUARD_UNIT_BIT 7
`define RXCFG_ST_PERR  0
`define RXCFG_ST_EMD   1
`define RXCFG_ST_DONE  2
`define RXCFG_ST_IGN   3
`define RXCFG_ST_BUSY  4

// ==========================================================================
// reset values and writable masks
`define RXCFG_RST_CTRL   8'h04
`define RXCFG_RST_GUARD  8'h00
`define RXCFG_RST_THR    8'h00
`define RXCFG_RST_FE     8'h10
`define RXCFG_MASK_CTRL  8'h1F
`define RXCFG_MASK_FE    8'hF3
`define RXCFG_STAT_W1C   8'h07

// ==========================================================================
// timing: clock and carrier in kHz, baud rates in kBd
`define RXCFG_CLK_KHZ      200000
`define RXCFG_CARRIER_KHZ  13560
`define RXCFG_CARRIER_PERIODS 16
`define RXCFG_CARRIER_UNIT_CYC ((`RXCFG_CARRIER_PERIODS * `RXCFG_CLK_KHZ \
	+ `RXCFG_CARRIER_KHZ - 1) / `RXCFG_CARRIER_KHZ)
`define RXCFG_KBD_2 26
`define RXCFG_KBD_3 52
`define RXCFG_KBD_4 106
`define RXCFG_KBD_5 212
`define RXCFG_KBD_6 424
`define RXCFG_KBD_7 847

`endif

// ---- rxcfg_pkg.sv ----
// types shared by the receiver configuration block
package rxcfg_pkg;

	// ======================================================================
	// configuration carried into the receive path
	typedef struct packed {
		logic       single_input_select;
		logic       converter_mode_select;
		logic [1:0] signal_source_select;
		logic [1:0] collision_threshold_level;
		logic [3:0] decoder_min_threshold;
		logic [3:0] phase_detector_threshold;
		logic [2:0] data_bit_rate;
		logic       disturbance_suppress_enable;
		logic       guard_time_check_enable;
	} rxcfg_active_s;

	// receive path events, each a one-cycle pulse
	typedef struct packed {
		logic sof;
		logic byte_valid;
		logic error;
		logic collision;
		logic frame_end;
	} rxcfg_rx_s;

	// ======================================================================
	// state encodings
	typedef enum logic {
		GD_IDLE = 1'b0,
		GD_RUN  = 1'b1
	} rxcfg_guard_e;

	typedef enum logic [1:0] {
		EM_IDLE = 2'b00,
		EM_HEAD = 2'b01,
		EM_BODY = 2'b10
	} rxcfg_emd_e;

endpackage

// ---- rxcfg_guard_timer.sv ----
// post-transmit guard timer that raises rx_ignore; it does not gate the receiver input
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_params.svh"

module rxcfg_guard_timer
	import rxcfg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       tx_end,
	input  wire logic       unit_select,
	input  wire logic [6:0] guard_count,
	input  wire logic [2:0] data_bit_rate,
	output logic            rx_ignore
);

	// reserved rate codes fall back to the carrier unit
	function automatic logic [11:0] unit_cycles(input logic sel,
			input logic [2:0] rate);
		int kbd;
		kbd = 0;
		case (rate)
			3'h2: kbd = `RXCFG_KBD_2;
			3'h3: kbd = `RXCFG_KBD_3;
			3'h4: kbd = `RXCFG_KBD_4;
			3'h5: kbd = `RXCFG_KBD_5;
			3'h6: kbd = `RXCFG_KBD_6;
			3'h7: kbd = `RXCFG_KBD_7;
			default: kbd = 0;
		endcase
		if (sel && kbd != 0) begin
			unit_cycles = 12'((`RXCFG_CLK_KHZ + 2 * kbd - 1) / (2 * kbd));
		end else begin
			unit_cycles = 12'(`RXCFG_CARRIER_UNIT_CYC);
		end
	endfunction

	rxcfg_guard_e state_q;
	logic [11:0]  unit_q;
	logic [11:0]  pre_q;
	logic [6:0]   left_q;
	wire  [11:0]  unit_d = unit_cycles(unit_select, data_bit_rate);
	wire          unit_done = (pre_q == unit_q);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= GD_IDLE;
			unit_q  <= 12'h001;
			pre_q   <= 12'h001;
			left_q  <= 7'h00;
		end else if (tx_end) begin
			state_q <= (guard_count != 7'h00) ? GD_RUN : GD_IDLE;
			unit_q  <= unit_d;
			pre_q   <= 12'h001;
			left_q  <= guard_count;
		end else if (state_q == GD_RUN) begin
			pre_q <= unit_done ? 12'h001 : pre_q + 12'h001;
			if (unit_done) begin
				left_q <= left_q - 7'h01;
				if (left_q == 7'h01) begin
					state_q <= GD_IDLE;
				end
			end
		end
	end

	assign rx_ignore = (state_q == GD_RUN);

	// ======================================================================
	// checks
	logic [18:0] exp_q;
	logic [18:0] run_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			exp_q <= 19'h00000;
			run_q <= 19'h00000;
		end else begin
			if (tx_end) begin
				exp_q <= 19'(guard_count) * 19'(unit_d);
			end
			run_q <= tx_end ? 19'h00000 : (rx_ignore ? run_q + 19'h00001 : run_q);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_guard_start: assert property (tx_end |=> rx_ignore ==
		($past(guard_count) != 7'h00)) else $error("guard start wrong");
	a_guard_span: assert property ($fell(rx_ignore) && !$past(tx_end)
		|-> run_q == exp_q) else $error("guard length wrong");
	c_guard_run: cover property (tx_end && guard_count == 7'h02 ##1 rx_ignore);
endmodule // rxcfg_guard_timer
`default_nettype wire

// ---- rxcfg_emd_filter.sv ----
// interference filter over the first bytes of a frame
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_params.svh"

module rxcfg_emd_filter
	import rxcfg_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      rst,
	input  wire rxcfg_rx_s rx_in,
	input  wire logic      suppress,
	input  wire logic      coll_enable,
	output logic           fifo_flush,
	output logic           rx_complete,
	output logic           emd_event
);

	rxcfg_emd_e state_q;
	logic [1:0] cnt_q;
	wire        err = rx_in.error | (rx_in.collision & coll_enable);
	wire [1:0]  bytes_n = cnt_q + {1'b0, rx_in.byte_valid};
	wire        head = (state_q == EM_HEAD);
	wire        discard = head & suppress & err;
	wire        short_end = head & suppress & rx_in.frame_end & ~err
		& (bytes_n != 2'd3);
	wire        good_end = rx_in.frame_end & ~discard & ~short_end
		& (state_q != EM_IDLE);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= EM_IDLE;
			cnt_q   <= 2'd0;
		end else begin
			case (state_q)
				EM_IDLE: begin
					cnt_q <= 2'd0;
					if (rx_in.sof) begin
						state_q <= EM_HEAD;
					end
				end
				EM_HEAD: begin
					if (discard) begin
						cnt_q <= 2'd0;
					end else if (rx_in.frame_end) begin
						state_q <= EM_IDLE;
					end else if (bytes_n == 2'd3) begin
						state_q <= EM_BODY;
					end else begin
						cnt_q <= bytes_n;
					end
				end
				EM_BODY: begin
					if (rx_in.frame_end) begin
						state_q <= EM_IDLE;
					end
				end
				default: state_q <= EM_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fifo_flush  <= 1'b0;
			rx_complete <= 1'b0;
			emd_event   <= 1'b0;
		end else begin
			fifo_flush  <= discard | short_end;
			emd_event   <= discard | short_end;
			rx_complete <= good_end;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_emd_discard: assert property (head && suppress && rx_in.error
		|=> fifo_flush && emd_event && !rx_complete)
		else $error("interference not discarded");
	a_emd_collision: assert property (head && suppress && coll_enable
		&& rx_in.collision |=> fifo_flush) else $error("collision ignored");
	a_emd_short: assert property (emd_event |-> !rx_complete)
		else $error("complete raised on interference");
	c_emd_short: cover property (short_end ##1 emd_event);
endmodule // rxcfg_emd_filter
`default_nettype wire

// ---- rxcfg_card_model.sv ----
// card model driving receive event pulses
`timescale 1ns/1ps
`default_nettype none

module rxcfg_card_model
	import rxcfg_pkg::*;
(
	input  wire logic      ref_clk,
	output var  rxcfg_rx_s rx_in
);
	initial rx_in = '0;
	// byte bad carries an error, or a collision if coll is set
	task automatic frame(input int n, bad, input logic coll, input int gap);
		rx_in.sof <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			rx_in <= '0;
			repeat (gap) @(posedge ref_clk);
			rx_in.byte_valid <= 1'b1;
			rx_in.error <= i == bad && !coll;
			rx_in.collision <= i == bad && coll;
		end
		@(posedge ref_clk);
		rx_in <= '0;
		@(posedge ref_clk);
		rx_in.frame_end <= 1'b1;
		@(posedge ref_clk);
		rx_in <= '0;
	endtask
endmodule // rxcfg_card_model

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the receiver configuration block
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_params.svh"

module tb_top
	import rxcfg_pkg::*;
;
	localparam logic [11:0] A_CTRL = 12'h0D4;
	localparam logic [11:0] A_GRD  = 12'h0D8;
	localparam logic [11:0] A_THR  = 12'h0DC;
	localparam logic [11:0] A_FE   = 12'h0E0;
	localparam logic [11:0] A_ST   = 12'h0FC;
	localparam int          KBD[8] = '{0, 0, 26, 52, 106, 212, 424, 847};
	localparam int          U      = `RXCFG_CARRIER_UNIT_CYC;
	logic          ref_clk, rst, awv, wv, bry, arv, rry, tx_end, type_b;
	logic          awr, wr_y, bv, arr, rv, ign, flush, done, perr;
	logic [11:0]   awa, ara;
	logic [31:0]   wd, rd, dr;
	logic [3:0]    ws;
	logic [1:0]    br, rr, resp;
	rxcfg_rx_s     rx_in;
	rxcfg_active_s act;
	int            failures, comparisons, cyc, n_fl, n_dn, n_pe;

	rxcfg_receiver #(.EGT_MAX_CYCLES(12'h010)) u_rxcfg_receiver (
		.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_y),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .tx_end(tx_end), .type_b_mode(type_b),
		.rx_in(rx_in), .active_cfg(act), .rx_ignore(ign),
		.fifo_flush(flush), .rx_complete(done), .protocol_error(perr));
	rxcfg_card_model u_rxcfg_card_model (.ref_clk(ref_clk), .rx_in(rx_in));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// the ceiling also counts pulses, so a hang ends in the report
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		n_fl <= n_fl + flush;
		n_dn <= n_dn + done;
		n_pe <= n_pe + perr;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	// =======
	// bus and compare tasks
	task automatic chk(input string w, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awr) awv <= 1'b0;
			if (wr_y) wv <= 1'b0;
		end while (awv && !awr || wv && !wr_y);
		while (!bv) @(posedge ref_clk);
		resp = br;
	endtask
	task automatic rd_reg(input logic [11:0] a);
		ara <= a;
		arv <= 1'b1;
		do @(posedge ref_clk); while (!arr);
		arv <= 1'b0;
		do @(posedge ref_clk); while (!rv);
		dr = rd;
		resp = rr;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// =======
	// scenarios
	task automatic t_regs();
		rd_reg(A_CTRL);
		chk("ctrl reset", `RXCFG_RST_CTRL, dr);
		wr_reg(A_FE, 8'hFF);
		rd_reg(A_FE);
		chk("fe fields", 8'hF3, dr);
		wr_reg(12'h000, 8'hFF);
		chk("unmapped bresp", 2'b10, resp);
		rd_reg(12'h000);
		chk("unmapped rresp", 2'b10, resp);
		ws <= 4'h0;
		wr_reg(A_THR, 8'h11);
		ws <= 4'hF;
		rd_reg(A_THR);
		chk("strobe off", `RXCFG_RST_THR, dr);
	endtask
	task automatic t_cfg();
		wr_reg(A_CTRL, 8'h1F);
		wr_reg(A_THR, 8'hA5);
		u_rxcfg_card_model.frame(3, -1, 1'b0, 1);
		chk("active cfg", {6'h3F, 8'hA5, 5'h1F}, act);
		wr_reg(A_THR, 8'h5A);
		chk("cfg held", {6'h3F, 8'hA5, 5'h1F}, act);
		u_rxcfg_card_model.frame(3, -1, 1'b0, 1);
		chk("cfg next frame", {6'h3F, 8'h5A, 5'h1F}, act);
	endtask
	task automatic t_guard(input logic [7:0] g, input int unit);
		int n;
		wr_reg(A_GRD, g);
		tx_end <= 1'b1;
		@(posedge ref_clk);
		tx_end <= 1'b0;
		#1;
		n = 0;
		while (ign === 1'b1 && n < 9000) begin
			n++;
			@(posedge ref_clk);
			#1;
		end
		chk("ignore cycles", g[6:0] * unit, n);
	endtask
	task automatic emd_case(input int n, bad, input logic c, input int f, d);
		int f0, d0;
		f0 = n_fl;
		d0 = n_dn;
		u_rxcfg_card_model.frame(n, bad, c, 1);
		repeat (4) @(posedge ref_clk);
		chk("flush count", f, n_fl - f0);
		chk("complete count", d, n_dn - d0);
	endtask
	task automatic t_egt(input logic b, input int e);
		int p0;
		wr_reg(A_CTRL, 8'h1B);
		type_b <= b;
		p0 = n_pe;
		u_rxcfg_card_model.frame(3, -1, 1'b0, 40);
		repeat (4) @(posedge ref_clk);
		chk("egt error", e, n_pe != p0);
	endtask
	task automatic t_stat();
		rd_reg(A_ST);
		chk("status sticky", 8'h07, dr);
		wr_reg(A_ST, 8'h07);
		rd_reg(A_ST);
		chk("status cleared", 8'h00, dr);
	endtask

	initial begin
		{awv, wv, arv, tx_end, type_b} = '0;
		{bry, rry} = 2'h3;
		{awa, ara, wd} = '0;
		ws = 4'hF;
		rst = 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_cfg();
		for (int r = 1; r < 8; r++) begin
			wr_reg(A_CTRL, {5'h03, r[2:0]});
			t_guard(8'h82, r < 2 ? U : (`RXCFG_CLK_KHZ + 2 * KBD[r] - 1)
				/ (2 * KBD[r]));
		end
		t_guard(8'h03, U);
		wr_reg(A_FE, 8'hF0);
		wr_reg(A_CTRL, 8'h0B);
		emd_case(2, -1, 1'b0, 1, 0);
		emd_case(6, 1, 1'b0, 1, 1);
		emd_case(6, 1, 1'b1, 1, 1);
		emd_case(3, -1, 1'b0, 0, 1);
		wr_reg(A_FE, 8'hF3);
		emd_case(6, 1, 1'b1, 0, 1);
		t_egt(1'b1, 1);
		t_egt(1'b0, 0);
		t_stat();
		tally_and_finish();
	end
endmodule // tb_top

`default_nettype wire
